// ==== hw/sfram_pkg.sv ====
// Shared constants and types for both ends of the serial memory link
package sfram_pkg;

   // ---------------------------------------------------------------
   // Command opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_SET_WL  = 8'h06;
   localparam logic [7:0] OP_CLR_WL  = 8'h04;
   localparam logic [7:0] OP_SR_RD   = 8'h05;
   localparam logic [7:0] OP_SR_WR   = 8'h01;
   localparam logic [7:0] OP_MEM_RD  = 8'h03;
   localparam logic [7:0] OP_MEM_WR  = 8'h02;

   // ---------------------------------------------------------------
   // Array geometry and address layout
   // ---------------------------------------------------------------
   localparam int         BYTE_W     = 8;
   localparam int         ADDR_W     = 11;
   localparam int         ADDR_HI_W  = 3;
   localparam int         MEM_DEPTH  = 2048;
   localparam logic [4:0] ADDR_PAD   = 5'h00;
   localparam logic [2:0] LAST_BIT   = 3'h7;
   localparam logic [2:0] FIRST_BIT  = 3'h0;

   // ---------------------------------------------------------------
   // Status register layout
   // ---------------------------------------------------------------
   localparam int         SR_SPE_BIT = 7;
   localparam int         SR_WL_BIT  = 1;
   localparam logic [7:0] SR_RESET   = 8'h00;
   localparam logic [7:0] SR_WR_MASK = 8'h8C;

   // ---------------------------------------------------------------
   // Timing: serial clock ceiling and master divider
   // ---------------------------------------------------------------
   localparam int         SCK_MAX_MHZ  = 16;
   localparam int         MCLK_MHZ     = 125;
   localparam int         SCK_HALF_CYC = (MCLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
   localparam logic [2:0] DIV_LAST     = 3'(SCK_HALF_CYC - 1);

   // ---------------------------------------------------------------
   // Frame lengths in bits
   // ---------------------------------------------------------------
   localparam logic [5:0] FRAME_OP_BITS  = 6'h08;
   localparam logic [5:0] FRAME_SR_BITS  = 6'h10;
   localparam logic [5:0] FRAME_MEM_BITS = 6'h20;

   // ---------------------------------------------------------------
   // State encodings
   // ---------------------------------------------------------------
   typedef enum logic [6:0] {
      DS_OPC = 7'h01,
      DS_ADH = 7'h02,
      DS_ADL = 7'h04,
      DS_MWR = 7'h08,
      DS_MRD = 7'h10,
      DS_SR  = 7'h20,
      DS_IGN = 7'h40
   } sfram_dst_t;

   typedef enum logic [3:0] {
      HS_IDLE  = 4'h1,
      HS_SEL   = 4'h2,
      HS_SHIFT = 4'h4,
      HS_GAP   = 4'h8
   } sfram_hst_t;

endpackage : sfram_pkg

// ==== hw/sfram_if.sv ====
// Link wires between the serial memory and its master
interface sfram_if;
   logic cs_n;
   logic sck;
   logic mosi;
   logic hold_n;
   logic wp_n;
   logic so_o;
   logic so_oe;
   wire  so_line;

   // Released output shows the inverse of the last bit, so a late sample stands out
   assign so_line = so_oe ? so_o : ~so_o;

   modport dev  (input cs_n, sck, mosi, hold_n, wp_n, output so_o, so_oe);
   modport host (output cs_n, sck, mosi, hold_n, wp_n, input so_line);
endinterface : sfram_if

// ==== hw/sfram_dev.sv ====
// Serial memory end of the link: framing, decode, array and status

// How it works
// - Select high: standby, inputs ignored, output released.
// - Select low enables internal serial clock shifting.
// - Master starts every opcode with a select fall.
// - Capture at rising edges, shift out at falling.
// - Serial clock zero to 16 MHz, may stop.
// - Output driven only during reads, never while paused.
// - Protect bit plus low protect pin blocks status writes.
// - Pause low freezes work, ignores clock and select; a select fall still captures mode.
// - Master changes pause only while clock low.
// - Array holds 2K bytes, shifted one bit per clock.
// - Two address bytes, top five bits ignored.
// - First byte after select fall is the opcode.
// - Master raises select after each finished command.
// - Byte writes complete within the transfer itself.
// - Both modes capture from first rising edge.
// - Six opcodes decoded: latch, status, memory access.
// - Latch set by its opcode, cleared at select rise after a latch clear, status write or memory write opcode.
// - Clock level at select fall picks mode.
// - Unknown opcode ignores rest of frame, output released.
module sfram_dev (
   // Link pins
   sfram_if.dev             link,
   // System clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // Status levels in the system clock domain
   output logic             write_latch_flag,
   output logic             status_protect_enable,
   output logic             mode3_flag
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   sfram_pkg::sfram_dst_t                st_ff, nxt_st;
   logic [2:0]                           bit_ff, nxt_bit;
   logic [6:0]                           rx_ff, nxt_rx;
   logic [7:0]                           op_ff, nxt_op;
   logic [sfram_pkg::ADDR_W-1:0]         addr_ff, nxt_addr;
   logic                                 wl_ff, nxt_wl;
   logic                                 pend_ff, nxt_pend;
   logic [7:0]                           sr_ff, nxt_sr;
   logic [6:0]                           tx_ff, nxt_tx;
   logic                                 so_ff, nxt_so;
   logic                                 oe_ff, nxt_oe;
   logic                                 mode3_ff, nxt_mode3;
   logic                                 rst_s1_ff, rst_s2_ff;
   logic [2:0]                           sync1_ff, sync2_ff;
   logic [7:0]                           mem_ff [0:sfram_pkg::MEM_DEPTH-1];
   logic                                 frame_clr;
   logic                                 byte_done;
   logic [7:0]                           rx_byte;
   logic [7:0]                           st_byte;
   logic [7:0]                           rd_byte;
   logic                                 rd_active;
   logic                                 first_edge;
   logic                                 mem_we;
   logic                                 sr_we;
   logic                                 wl_view;

   // ---------------------------------------------------------------
   // Frame framing and shared terms
   // ---------------------------------------------------------------
   // Select high clears the frame; pause masks select changes
   assign frame_clr  = link.cs_n & link.hold_n;
   assign byte_done  = (bit_ff == sfram_pkg::LAST_BIT);
   assign rx_byte    = {rx_ff, link.mosi};
   assign first_edge = (st_ff == sfram_pkg::DS_OPC) && (bit_ff == sfram_pkg::FIRST_BIT);
   assign rd_active  = (st_ff == sfram_pkg::DS_MRD)
                     || ((st_ff == sfram_pkg::DS_SR) && (op_ff == sfram_pkg::OP_SR_RD));
   // Array write completes at the rising edge of the last data bit
   assign mem_we     = link.hold_n && byte_done && wl_ff
                     && (st_ff == sfram_pkg::DS_MWR);
   // Status write needs the latch and is blocked by pin plus enable bit
   assign sr_we      = link.hold_n && byte_done && wl_ff
                     && (st_ff == sfram_pkg::DS_SR) && (op_ff == sfram_pkg::OP_SR_WR)
                     && !(sr_ff[sfram_pkg::SR_SPE_BIT] && !link.wp_n);
   // Latch seen as cleared once select has risen after a clearing command
   assign wl_view    = wl_ff & ~(pend_ff & link.cs_n);

   // Status byte and read data source
   always_comb begin
      st_byte                       = sr_ff;
      st_byte[sfram_pkg::SR_WL_BIT] = wl_ff;
      if (st_ff == sfram_pkg::DS_MRD) begin
         rd_byte = mem_ff[addr_ff];
      end else begin
         rd_byte = st_byte;
      end
   end

   // ---------------------------------------------------------------
   // Command decode, rising edge of the serial clock
   // ---------------------------------------------------------------
   // Next frame state, bit count, opcode and address
   always_comb begin
      nxt_st   = st_ff;
      nxt_bit  = bit_ff;
      nxt_rx   = rx_ff;
      nxt_op   = op_ff;
      nxt_addr = addr_ff;
      if (link.hold_n) begin
         nxt_bit = bit_ff + 3'h1;
         nxt_rx  = rx_byte[6:0];
         if (byte_done) begin
            case (st_ff)
               sfram_pkg::DS_OPC: begin
                  nxt_op = rx_byte;
                  if (rx_byte == sfram_pkg::OP_MEM_RD || rx_byte == sfram_pkg::OP_MEM_WR) begin
                     nxt_st = sfram_pkg::DS_ADH;
                  end else if (rx_byte == sfram_pkg::OP_SR_RD
                               || rx_byte == sfram_pkg::OP_SR_WR) begin
                     nxt_st = sfram_pkg::DS_SR;
                  end else begin
                     nxt_st = sfram_pkg::DS_IGN;
                  end
               end
               sfram_pkg::DS_ADH: begin
                  // Upper five address bits dropped
                  nxt_addr = {rx_byte[sfram_pkg::ADDR_HI_W-1:0], addr_ff[7:0]};
                  nxt_st   = sfram_pkg::DS_ADL;
               end
               sfram_pkg::DS_ADL: begin
                  nxt_addr = {addr_ff[sfram_pkg::ADDR_W-1:8], rx_byte};
                  if (op_ff == sfram_pkg::OP_MEM_RD) begin
                     nxt_st = sfram_pkg::DS_MRD;
                  end else begin
                     nxt_st = sfram_pkg::DS_MWR;
                  end
               end
               sfram_pkg::DS_MRD, sfram_pkg::DS_MWR: begin
                  nxt_addr = addr_ff + 11'h001;
               end
               default: begin
                  nxt_st = st_ff;
               end
            endcase
         end
      end
   end

   // Frame registers, cleared while select is high and pause is high
   always_ff @(posedge link.sck or posedge frame_clr) begin
      if (frame_clr) begin
         st_ff   <= sfram_pkg::DS_OPC;
         bit_ff  <= sfram_pkg::FIRST_BIT;
         rx_ff   <= 7'h00;
         op_ff   <= 8'h00;
         addr_ff <= 11'h000;
      end else begin
         st_ff   <= nxt_st;
         bit_ff  <= nxt_bit;
         rx_ff   <= nxt_rx;
         op_ff   <= nxt_op;
         addr_ff <= nxt_addr;
      end
   end

   // ---------------------------------------------------------------
   // Write latch and status register, kept across frames
   // ---------------------------------------------------------------
   // Pending clear is committed at the first edge of the next frame
   always_comb begin
      nxt_wl   = wl_ff;
      nxt_pend = pend_ff;
      nxt_sr   = sr_ff;
      if (rst_s2_ff) begin
         nxt_wl   = 1'b0;
         nxt_pend = 1'b0;
         nxt_sr   = sfram_pkg::SR_RESET;
      end else if (link.hold_n) begin
         if (first_edge && pend_ff) begin
            nxt_wl   = 1'b0;
            nxt_pend = 1'b0;
         end
         if (byte_done && (st_ff == sfram_pkg::DS_OPC)) begin
            if (rx_byte == sfram_pkg::OP_SET_WL) begin
               nxt_wl = 1'b1;
            end
            if (rx_byte == sfram_pkg::OP_CLR_WL || rx_byte == sfram_pkg::OP_SR_WR
                || rx_byte == sfram_pkg::OP_MEM_WR) begin
               nxt_pend = 1'b1;
            end
         end
         if (sr_we) begin
            nxt_sr = rx_byte & sfram_pkg::SR_WR_MASK;
         end
      end
   end

   always_ff @(posedge link.sck) begin
      wl_ff   <= nxt_wl;
      pend_ff <= nxt_pend;
      sr_ff   <= nxt_sr;
   end

   // Byte array, written at bus speed
   always_ff @(posedge link.sck) begin
      if (mem_we) begin
         mem_ff[addr_ff] <= rx_byte;
      end
   end

   // Reset level carried into the serial clock domain
   always_ff @(posedge link.sck) begin
      rst_s1_ff <= reset;
      rst_s2_ff <= rst_s1_ff;
   end

   // ---------------------------------------------------------------
   // Serial output, falling edge of the serial clock
   // ---------------------------------------------------------------
   // Load a byte at each byte boundary of a read, else shift left
   always_comb begin
      nxt_tx = tx_ff;
      nxt_so = so_ff;
      nxt_oe = oe_ff;
      if (link.hold_n && rd_active) begin
         nxt_oe = 1'b1;
         if (bit_ff == sfram_pkg::FIRST_BIT) begin
            {nxt_so, nxt_tx} = rd_byte;
         end else begin
            {nxt_so, nxt_tx} = {tx_ff, 1'b0};
         end
      end
   end

   always_ff @(negedge link.sck or posedge frame_clr) begin
      if (frame_clr) begin
         tx_ff <= 7'h00;
         so_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else begin
         tx_ff <= nxt_tx;
         so_ff <= nxt_so;
         oe_ff <= nxt_oe;
      end
   end

   // Released outside reads, after bad opcodes and while paused
   assign link.so_o  = so_ff;
   assign link.so_oe = oe_ff & link.hold_n & ~link.cs_n;

   // ---------------------------------------------------------------
   // Mode capture at the select fall
   // ---------------------------------------------------------------
   // Clock low selects mode 0, high selects mode 3
   assign nxt_mode3 = link.sck;

   always_ff @(negedge link.cs_n) begin
      mode3_ff <= nxt_mode3;
   end

   // ---------------------------------------------------------------
   // Status levels into the system clock domain
   // ---------------------------------------------------------------
   // Two-stage level synchroniser
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync1_ff <= 3'h0;
         sync2_ff <= 3'h0;
      end else begin
         sync1_ff <= {mode3_ff, sr_ff[sfram_pkg::SR_SPE_BIT], wl_view};
         sync2_ff <= sync1_ff;
      end
   end

   assign write_latch_flag      = sync2_ff[0];
   assign status_protect_enable = sync2_ff[1];
   assign mode3_flag            = sync2_ff[2];

endmodule : sfram_dev

// ==== hw/sfram_host.sv ====
// Master end of the link: frames commands and returns read bytes
module sfram_host (
   // Link pins
   sfram_if.host                          link,
   // Clock and reset
   input  wire logic                      mclk,
   input  wire logic                      reset,
   // Command request
   input  wire logic                      cmd_valid,
   output logic                           cmd_ready,
   input  wire logic [7:0]                cmd_op,
   input  wire logic [sfram_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic [7:0]                cmd_wdata,
   input  wire logic                      cmd_mode3,
   // Read byte answer
   output logic                           rsp_valid,
   input  wire logic                      rsp_ready,
   output logic [7:0]                     rsp_data,
   // Pause request and protect level
   input  wire logic                      hold_req,
   input  wire logic                      wp_level
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   sfram_pkg::sfram_hst_t st_ff, nxt_st;
   logic [2:0]            div_ff, nxt_div;
   logic                  half_ff, nxt_half;
   logic                  sck_ff, nxt_sck;
   logic                  cs_n_ff, nxt_cs_n;
   logic                  hold_n_ff, nxt_hold_n;
   logic [5:0]            bits_ff, nxt_bits;
   logic [31:0]           tx_ff, nxt_tx;
   logic [6:0]            rx_ff, nxt_rx;
   logic                  rd_ff, nxt_rd;
   logic                  m3_ff, nxt_m3;
   logic                  so_s1_ff, so_s2_ff, wp_ff;
   logic [7:0]            q_ff [0:1];
   logic                  wptr_ff, rptr_ff;
   logic [1:0]            cnt_ff, nxt_cnt;
   logic                  tick, push, pop;

   // ---------------------------------------------------------------
   // Frame sequencer
   // ---------------------------------------------------------------
   assign tick      = (div_ff == sfram_pkg::DIV_LAST) && hold_n_ff;
   assign cmd_ready = (st_ff == sfram_pkg::HS_IDLE) && (cnt_ff != 2'h2);

   // Divider, clock phases, select and shifting
   always_comb begin
      nxt_st     = st_ff;
      nxt_half   = half_ff;
      nxt_sck    = sck_ff;
      nxt_cs_n   = cs_n_ff;
      nxt_hold_n = hold_n_ff;
      nxt_bits   = bits_ff;
      nxt_tx     = tx_ff;
      nxt_rx     = rx_ff;
      nxt_rd     = rd_ff;
      nxt_m3     = m3_ff;
      push       = 1'b0;
      nxt_div    = (tick || st_ff == sfram_pkg::HS_IDLE) ? 3'h0 : div_ff + 3'h1;
      if (!hold_n_ff) begin
         nxt_div = div_ff;
      end
      case (st_ff)
         sfram_pkg::HS_IDLE: begin
            if (cmd_valid && cmd_ready) begin
               nxt_m3   = cmd_mode3;
               nxt_sck  = cmd_mode3;                     // Idle level names the mode
               nxt_rd   = (cmd_op == sfram_pkg::OP_SR_RD) || (cmd_op == sfram_pkg::OP_MEM_RD);
               nxt_half = 1'b0;
               nxt_st   = sfram_pkg::HS_SEL;
               if (cmd_op == sfram_pkg::OP_MEM_RD || cmd_op == sfram_pkg::OP_MEM_WR) begin
                  nxt_tx   = {cmd_op, sfram_pkg::ADDR_PAD, cmd_addr, cmd_wdata};
                  nxt_bits = sfram_pkg::FRAME_MEM_BITS;
               end else if (cmd_op == sfram_pkg::OP_SR_RD || cmd_op == sfram_pkg::OP_SR_WR) begin
                  nxt_tx   = {cmd_op, cmd_wdata, 16'h0000};
                  nxt_bits = sfram_pkg::FRAME_SR_BITS;
               end else begin
                  nxt_tx   = {cmd_op, 24'h00_0000};
                  nxt_bits = sfram_pkg::FRAME_OP_BITS;
               end
            end
         end
         sfram_pkg::HS_SEL: begin
            if (tick && !half_ff) begin
               nxt_cs_n = 1'b0;
               nxt_half = 1'b1;
            end else if (tick) begin
               nxt_sck  = 1'b0;
               nxt_half = 1'b0;
               nxt_st   = sfram_pkg::HS_SHIFT;
            end
         end
         sfram_pkg::HS_SHIFT: begin
            if (!half_ff && !tick) begin
               nxt_hold_n = !hold_req;
            end
            if (tick && !half_ff) begin
               nxt_sck  = 1'b1;
               nxt_half = 1'b1;
            end else if (tick) begin
               nxt_rx   = {rx_ff[5:0], so_s2_ff};
               nxt_tx   = {tx_ff[30:0], 1'b0};
               nxt_bits = bits_ff - 6'h01;
               nxt_half = 1'b0;
               nxt_sck  = 1'b0;
               if (bits_ff == 6'h01) begin
                  nxt_sck = m3_ff;
                  push    = rd_ff;
                  nxt_st  = sfram_pkg::HS_GAP;
               end
            end
         end
         sfram_pkg::HS_GAP: begin
            if (tick && !half_ff) begin
               nxt_cs_n = 1'b1;
               nxt_half = 1'b1;
            end else if (tick) begin
               nxt_half = 1'b0;
               nxt_st   = sfram_pkg::HS_IDLE;
            end
         end
         default: begin
            nxt_st = sfram_pkg::HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_ff     <= sfram_pkg::HS_IDLE;
         div_ff    <= 3'h0;
         half_ff   <= 1'b0;
         sck_ff    <= 1'b0;
         cs_n_ff   <= 1'b1;
         hold_n_ff <= 1'b1;
         bits_ff   <= 6'h00;
         tx_ff     <= 32'h0000_0000;
         rx_ff     <= 7'h00;
         rd_ff     <= 1'b0;
         m3_ff     <= 1'b0;
         wp_ff     <= 1'b1;
      end else begin
         st_ff     <= nxt_st;
         div_ff    <= nxt_div;
         half_ff   <= nxt_half;
         sck_ff    <= nxt_sck;
         cs_n_ff   <= nxt_cs_n;
         hold_n_ff <= nxt_hold_n;
         bits_ff   <= nxt_bits;
         tx_ff     <= nxt_tx;
         rx_ff     <= nxt_rx;
         rd_ff     <= nxt_rd;
         m3_ff     <= nxt_m3;
         wp_ff     <= wp_level;
      end
   end

   // Serial output of the memory, two stages before use
   always_ff @(posedge mclk) begin
      so_s1_ff <= link.so_line;
      so_s2_ff <= so_s1_ff;
   end

   assign link.cs_n   = cs_n_ff;
   assign link.sck    = sck_ff;
   assign link.mosi   = tx_ff[31];
   assign link.hold_n = hold_n_ff;
   assign link.wp_n   = wp_ff;

   // ---------------------------------------------------------------
   // Two-entry answer buffer
   // ---------------------------------------------------------------
   assign pop       = rsp_valid && rsp_ready;
   assign rsp_valid = (cnt_ff != 2'h0);
   assign rsp_data  = q_ff[rptr_ff];
   assign nxt_cnt   = cnt_ff + {1'b0, push} - {1'b0, pop};

   always_ff @(posedge mclk) begin
      if (reset) begin
         wptr_ff <= 1'b0;
         rptr_ff <= 1'b0;
         cnt_ff  <= 2'h0;
      end else begin
         wptr_ff <= wptr_ff ^ push;
         rptr_ff <= rptr_ff ^ pop;
         cnt_ff  <= nxt_cnt;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         q_ff[wptr_ff] <= {rx_ff[6:0], so_s2_ff};
      end
   end

endmodule : sfram_host

// ==== dv/sfram_sva.sv ====
// Link checker for the serial memory interface
module sfram_sva (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Link wires
   input wire logic cs_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic so_o,
   input wire logic so_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] bits_ff;
   logic [5:0] nxt_bits;
   logic       sck_ff;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // Rising serial clock edges seen in the frame
   always_comb nxt_bits = cs_n ? 6'h00 : bits_ff + 6'(sck & ~sck_ff);
   always_ff @(posedge mclk) begin
      bits_ff <= nxt_bits;
      sck_ff  <= sck;
   end
   sequence s_high;
      sck [*4];
   endsequence
   // Select stays high for a gap before the next opcode
   sequence s_gap;
      cs_n [*8];
   endsequence
   a_idle_release: assert property (cs_n |-> !so_oe)
      else $error("output driven while deselected");
   a_pause_release: assert property (!hold_n |-> !so_oe)
      else $error("output driven while paused");
   a_fall_shift: assert property (so_oe && $stable(so_oe) && $changed(so_o) |-> $fell(sck))
      else $error("output moved off a falling edge");
   a_clock_rate: assert property ($rose(sck) |-> s_high)
      else $error("serial clock high too short");
   a_frame_bits: assert property ($rose(cs_n) |-> bits_ff inside {6'h08, 6'h10, 6'h20})
      else $error("frame length wrong");
   a_drive_start: assert property ($rose(so_oe) |-> bits_ff inside {6'h08, 6'h18})
      else $error("output driven at wrong bit");
   a_pause_clk_low: assert property ($changed(hold_n) |-> !sck)
      else $error("pause moved while clock high");
   a_data_settled: assert property ($changed(mosi) && !cs_n |-> !$rose(sck))
      else $error("data moved at rising edge");
   a_select_gap: assert property ($rose(cs_n) |-> s_gap)
      else $error("select high too short between frames");
endmodule : sfram_sva

// ==== dv/sfram_bench.sv ====
// Bench with both link ends face to face
module sfram_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst_h = 1'b1, rst_d = 1'b1, cmd_valid = 1'b0, cmd_mode3 = 1'b0;
   logic rsp_ready = 1'b0, hold_req = 1'b0, wp_level = 1'b1;
   logic [7:0] cmd_op = 8'h00, cmd_wdata = 8'h00, rsp_data;
   logic [10:0] cmd_addr = 11'h000;
   logic cmd_ready, rsp_valid, wl, spe, m3;
   int fails = 0, compares = 0;
   sfram_if lnk ();
   sfram_dev u_sfram_dev (.link(lnk), .mclk(mclk), .reset(rst_d),
      .write_latch_flag(wl), .status_protect_enable(spe), .mode3_flag(m3));
   sfram_host u_sfram_host (.link(lnk), .mclk(mclk), .reset(rst_h), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_mode3(cmd_mode3), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp_data(rsp_data), .hold_req(hold_req), .wp_level(wp_level));
   sfram_sva u_sfram_sva (.mclk(mclk), .reset(rst_h), .cs_n(lnk.cs_n), .sck(lnk.sck),
      .mosi(lnk.mosi), .hold_n(lnk.hold_n), .wp_n(lnk.wp_n), .so_o(lnk.so_o), .so_oe(lnk.so_oe));
   always #4 mclk = ~mclk;
   task report_and_stop;
      $display("compares %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // Bounded wait for ready or for an answer byte
   task wt(input bit rsp);
      for (int n = 0; n < 3000; n++) begin
         @(negedge mclk);
         if ((rsp ? rsp_valid : cmd_ready) === 1'b1) return;
      end
      fails++;
      $display("mismatch at %0t: wait limit reached", $time);
      report_and_stop();
   endtask : wt
   task cmd(input logic [7:0] op, input logic [10:0] a, input logic [7:0] d, input logic m);
      wt(0);
      @(posedge mclk);
      {cmd_op, cmd_addr, cmd_wdata, cmd_mode3, cmd_valid} <= {op, a, d, m, 1'b1};
      @(posedge mclk);
      cmd_valid <= 1'b0;
      wt(0);
   endtask : cmd
   task rd(input logic [7:0] op, input logic [10:0] a, input logic m, input logic [7:0] e);
      cmd(op, a, 8'h00, m);
      wt(1);
      chk(rsp_data, e);
      @(posedge mclk) rsp_ready <= 1'b1;
      @(posedge mclk) rsp_ready <= 1'b0;
   endtask : rd
   // Main sequence
   initial begin
      repeat (4) @(posedge mclk);
      rst_h <= 1'b0;
      // Serial clock edges carry the reset into the memory
      cmd(8'h04, 11'h000, 8'h00, 1'b0);
      @(posedge mclk) rst_d <= 1'b0;
      cmd(8'h06, 11'h000, 8'h00, 1'b0);
      chk({7'h00, wl}, 8'h01);
      cmd(8'h02, 11'h123, 8'hA5, 1'b0);
      chk({7'h00, wl}, 8'h00);
      rd(8'h03, 11'h123, 1'b1, 8'hA5);
      chk({7'h00, m3}, 8'h01);
      // Latch is clear, so this write is refused
      cmd(8'h02, 11'h123, 8'h5A, 1'b0);
      fork
         rd(8'h03, 11'h123, 1'b0, 8'hA5);
         begin
            repeat (120) @(posedge mclk);
            hold_req <= 1'b1;
            repeat (40) @(posedge mclk);
            hold_req <= 1'b0;
         end
      join
      chk({7'h00, m3}, 8'h00);
      cmd(8'h06, 11'h000, 8'h00, 1'b0);
      chk({7'h00, wl}, 8'h01);
      cmd(8'h04, 11'h000, 8'h00, 1'b0);
      chk({7'h00, wl}, 8'h00);
      $display("test memory done");
      cmd(8'h06, 11'h000, 8'h00, 1'b0);
      cmd(8'h01, 11'h000, 8'h8C, 1'b0);
      rd(8'h05, 11'h000, 1'b0, 8'h8C);
      chk({7'h00, spe}, 8'h01);
      wp_level <= 1'b0;
      cmd(8'h06, 11'h000, 8'h00, 1'b0);
      cmd(8'h01, 11'h000, 8'h00, 1'b0);
      rd(8'h05, 11'h000, 1'b0, 8'h8C);
      wp_level <= 1'b1;
      cmd(8'h06, 11'h000, 8'h00, 1'b0);
      cmd(8'h01, 11'h000, 8'h00, 1'b0);
      rd(8'h05, 11'h000, 1'b0, 8'h00);
      // Undefined opcode one bit away from the latch set must not set it
      cmd(8'h86, 11'h000, 8'h00, 1'b0);
      chk({7'h00, wl}, 8'h00);
      $display("test status done");
      report_and_stop();
   end
endmodule : sfram_bench
